// file: hw/mac_checker.sv
// mode based access checker for memory and register accesses
`timescale 1ns/10ps
`default_nettype none
module mac_checker (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire mac_pkg::mac_mode_type I_CPU_MODE,
    input wire logic I_FW_FROM_SYS,
    input wire logic I_FW_INTEGRITY,
    input wire logic I_FW_EE_ENABLE,
    input wire logic I_DENY_ROM_FROM_EE,
    input wire logic I_DENY_CM_ROM,
    input wire logic I_DENY_CM_EE,
    input wire logic [7:0] I_EXCHANGE_BASE_LOW,
    input wire logic [7:0] I_EXCHANGE_BASE_HIGH,
    input wire logic [7:0] I_EXCHANGE_SIZE_LOW,
    input wire logic [7:0] I_EXCHANGE_SIZE_HIGH,
    input wire logic [15:0] I_FIREWALL_CONTROL_LOW,
    input wire logic [15:0] I_FIREWALL_CONTROL_HIGH,
    input wire logic I_PTR_WR,
    input wire logic [15:0] I_PTR_DATA,
    input wire logic I_SEG_WR,
    input wire logic [5:0] I_SEG_IDX,
    input wire mac_pkg::mac_seg_type I_SEG_ENTRY,
    input wire logic [5:0] I_EXEC_SEG,
    input wire logic I_CM_START,
    input wire logic I_CM_DONE,
    input wire logic I_REQ_VALID,
    input wire mac_pkg::mac_req_type I_REQ,
    output logic O_RESP_VALID,
    output logic O_GRANT,
    output logic O_DENY,
    output logic O_EXCEPTION,
    output logic O_CM_BUSY,
    output logic [15:0] O_SEG_PTR
);
    import mac_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************
    // copy machine mode and segment table
    // ************************************************************
    logic cm_busy;
    mac_mode_type cm_mode;
    mac_seg_type seg_data;
    mac_seg_type seg_exec;

    mac_cm_mode u_cm_mode (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_start(I_CM_START),
        .i_done(I_CM_DONE),
        .i_cpu_mode(I_CPU_MODE),
        .o_busy(cm_busy),
        .o_mode(cm_mode)
    );

    mac_seg_table #(
        .DEPTH(SEG_COUNT),
        .AW(SEG_IDX_W)
    ) u_seg_table (
        .i_clk(I_CLK),
        .i_wr(I_SEG_WR),
        .i_wr_idx(I_SEG_IDX),
        .i_wr_data(I_SEG_ENTRY),
        .i_rd_a_idx(I_REQ.seg),
        .i_rd_b_idx(I_EXEC_SEG),
        .o_rd_a(seg_data),
        .o_rd_b(seg_exec)
    );

    // ************************************************************
    // segment table pointer
    // ************************************************************
    logic [15:0] seg_ptr;
    wire ptr_wr_ok = I_PTR_WR && (I_CPU_MODE == MODE_SYS);

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            seg_ptr <= SEG_PTR_RESET;
        end else if (ptr_wr_ok) begin
            seg_ptr <= I_PTR_DATA;
        end
    end

    // ************************************************************
    // request stage
    // ************************************************************
    // copy requests use the frozen mode while the copy machine is busy
    wire use_cm = (I_REQ.src == SRC_COPY) && cm_busy;
    wire mac_mode_type take_mode = use_cm ? cm_mode : I_CPU_MODE;

    logic s1_v;
    mac_req_type s1_req;
    mac_mode_type s1_mode;
    logic s1_from_sys;
    logic s1_integ;

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s1_v <= 1'b0;
            s1_req <= '0;
            s1_mode <= MODE_BOOT;
            s1_from_sys <= 1'b0;
            s1_integ <= 1'b0;
        end else begin
            s1_v <= I_REQ_VALID;
            s1_req <= I_REQ;
            s1_mode <= take_mode;
            s1_from_sys <= I_FW_FROM_SYS;
            s1_integ <= I_FW_INTEGRITY;
        end
    end

    // ************************************************************
    // decode of the stored request
    // ************************************************************
    wire [15:0] a = s1_req.addr;
    wire op_r = (s1_req.op == OP_READ);
    wire op_w = (s1_req.op == OP_WRITE);
    wire op_x = (s1_req.op == OP_EXEC);
    wire op_rx = op_r || op_x;
    wire op_rw = op_r || op_w;

    wire m_boot = (s1_mode == MODE_BOOT);
    wire m_test = (s1_mode == MODE_TEST);
    wire m_fw = (s1_mode == MODE_FW);
    wire m_sys = (s1_mode == MODE_SYS);
    wire m_user = (s1_mode == MODE_USER);

    wire sp_rom = (s1_req.space == SP_ROM);
    wire sp_ee = (s1_req.space == SP_EE);
    wire sp_ram = (s1_req.space == SP_RAM);
    wire sp_sfr = (s1_req.space == SP_SFR);
    wire sp_op = (s1_req.space == SP_OPRAM);

    wire rom_test = sp_rom && (a < ROM_TEST_END);
    wire rom_fw = sp_rom && (a >= ROM_TEST_END) && (a < ROM_FW_END);
    wire rom_app = sp_rom && (a >= ROM_FW_END);
    wire ee_fw = sp_ee && (a < EE_FW_END);
    wire ee_app = sp_ee && (a >= EE_FW_END);
    wire ee_sec = ee_app && (a >= EE_SEC_LO) && (a <= EE_SEC_HI);
    wire ram_fw = sp_ram && (a < RAM_FW_END);
    wire ram_app = sp_ram && (a >= RAM_FW_END);

    // exchange window inside application ram
    wire [15:0] xbase = {I_EXCHANGE_BASE_HIGH, I_EXCHANGE_BASE_LOW};
    wire [15:0] xsize = {I_EXCHANGE_SIZE_HIGH, I_EXCHANGE_SIZE_LOW};
    wire [15:0] xoff = a - xbase;
    wire in_xchg = ram_app && (a >= xbase) && (xoff < xsize);

    // segment usable only with some right and a live table
    wire seg_on = (seg_ptr != 16'h0000) &&
        (seg_data.r || seg_data.w || seg_data.x);
    wire seg_ok = seg_on && ((op_r && seg_data.r) ||
        (op_w && seg_data.w) || (op_x && seg_data.x));

    // ************************************************************
    // memory rules
    // ************************************************************
    // boot mode memories
    wire boot_mem = (rom_test && op_rx) || ee_fw ||
        (ram_fw && op_rw);
    wire test_mem = (sp_rom && op_rx) || sp_ee || (sp_ram && op_rw);
    // firmware mode memories, firewall guards fw eeprom
    wire fw_mem = (rom_fw && op_rx) || (ram_fw && op_rw) ||
        (sp_ee && s1_integ && op_rw) || (ee_fw && I_FW_EE_ENABLE);
    wire fw_xchg = in_xchg && op_rw;
    wire sec_rd = ee_sec && op_r && (m_boot || m_fw);
    // application eeprom read and write when called from system
    wire fw_call = ee_app && op_rw && s1_from_sys;
    wire sys_mem = (rom_app && op_rx) || ee_app || (ram_app && op_rw);
    wire user_mem = seg_ok && ((rom_app && op_rx) || ee_app ||
        (ram_app && op_rw));
    wire op_ram = sp_op && op_rw &&
        ((s1_req.src == SRC_COPROC) || m_test);

    wire cfg_deny = sp_rom && op_r &&
        ((s1_req.exec_ee && s1_req.src == SRC_CPU && I_DENY_ROM_FROM_EE)
        || (s1_req.src == SRC_COPY && I_DENY_CM_ROM)) ||
        (sp_ee && op_r && s1_req.src == SRC_COPY && I_DENY_CM_EE);

    wire mem_mode_ok = (m_boot && boot_mem) || (m_test && test_mem) ||
        (m_fw && (fw_mem || fw_xchg || fw_call)) || sec_rd ||
        (m_sys && sys_mem) || (m_user && user_mem);
    wire mem_ok = !cfg_deny && (op_ram || (!sp_op && mem_mode_ok));

    // ************************************************************
    // register rules
    // ************************************************************
    wire [3:0] g = s1_req.grp;
    wire g_hw_like = (g == GRP_HW) || (g == GRP_CLKSEL) ||
        (g == GRP_KEY);
    wire fw_hw_ok = (op_r && I_FIREWALL_CONTROL_LOW[s1_req.hw_idx]) ||
        (op_w && I_FIREWALL_CONTROL_HIGH[s1_req.hw_idx]);
    wire user_hw_ok = (seg_ptr != 16'h0000) && seg_exec.hw[s1_req.hw_idx];

    wire boot_sfr = (g != GRP_TEST) && (g != GRP_SEGCFG) &&
        (g != GRP_BANK);
    wire test_sfr = (g != GRP_BANK);
    wire fw_sfr = (g == GRP_FWOWN) || (g == GRP_FWCFG && op_r) ||
        (g_hw_like && fw_hw_ok);
    wire sys_sfr = (g == GRP_SEGCFG) || (g == GRP_SYSMGT) ||
        (g == GRP_CSR) || (g == GRP_SMPTR) || (g == GRP_FWCFG) ||
        g_hw_like;
    wire user_sfr = g_hw_like && user_hw_ok;
    // general always, banked in system and user
    wire cpu_sfr = (g == GRP_GEN) || (g == GRP_BANK && (m_sys || m_user));
    wire csr_rd = (g == GRP_CSR) && op_r && (m_fw || m_user);
    wire clk_rd = (g == GRP_CLKSEL) && op_r && m_fw;
    wire no_read = op_r && ((g == GRP_SMPTR) || (g == GRP_KEY));
    wire seg_block = (g == GRP_SEGCFG) && !m_sys;
    wire bank_block = (g == GRP_BANK) && (m_boot || m_test || m_fw);

    wire sfr_mode_ok = (m_boot && boot_sfr) || (m_test && test_sfr) ||
        (m_fw && fw_sfr) || (m_sys && sys_sfr) || (m_user && user_sfr);
    wire sfr_ok = op_rw && !no_read && !seg_block && !bank_block &&
        (sfr_mode_ok || cpu_sfr || csr_rd || clk_rd);

    wire allow = sp_sfr ? sfr_ok : mem_ok;

    // ************************************************************
    // answer
    // ************************************************************
    // answer registered before the target acts
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RESP_VALID <= 1'b0;
            O_GRANT <= 1'b0;
            O_DENY <= 1'b0;
            O_EXCEPTION <= 1'b0;
        end else begin
            O_RESP_VALID <= s1_v;
            O_GRANT <= s1_v && allow;
            O_DENY <= s1_v && !allow;
            O_EXCEPTION <= s1_v && !allow && sp_sfr;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_CM_BUSY <= 1'b0;
            O_SEG_PTR <= SEG_PTR_RESET;
        end else begin
            O_CM_BUSY <= cm_busy;
            O_SEG_PTR <= seg_ptr;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!rst_n);

    sequence s_sfr(logic [3:0] grp);
        s1_v && sp_sfr && (g == grp);
    endsequence

    property p_latency;
        I_REQ_VALID |-> ##2 O_RESP_VALID;
    endproperty
    a_latency: assert property (p_latency)
        else $error("answer not two cycles after request");

    property p_segcfg;
        s_sfr(GRP_SEGCFG) ##0 !m_sys |=> O_DENY && !O_GRANT;
    endproperty
    a_segcfg: assert property (p_segcfg)
        else $error("segment config reached outside system mode");

    property p_bank;
        s_sfr(GRP_BANK) ##0 (m_boot || m_test || m_fw) |=> O_DENY;
    endproperty
    a_bank: assert property (p_bank)
        else $error("banked register reached in privileged mode");

    property p_noread;
        (s_sfr(GRP_SMPTR) or s_sfr(GRP_KEY)) ##0 op_r |=> O_DENY;
    endproperty
    a_noread: assert property (p_noread)
        else $error("secret register read granted");

    property p_gen;
        s_sfr(GRP_GEN) ##0 op_rw |=> O_GRANT;
    endproperty
    a_gen: assert property (p_gen)
        else $error("general cpu register denied");

    property p_csr;
        s_sfr(GRP_CSR) ##0 op_r && (m_fw || m_user) |=> O_GRANT;
    endproperty
    a_csr: assert property (p_csr)
        else $error("status register read denied");

    property p_clksel;
        s_sfr(GRP_CLKSEL) ##0 op_r && m_fw |=> O_GRANT;
    endproperty
    a_clksel: assert property (p_clksel)
        else $error("clock selection read denied in firmware");

    property p_exc;
        O_DENY && $past(sp_sfr) |-> O_EXCEPTION;
    endproperty
    a_exc: assert property (p_exc)
        else $error("register denial without exception");

    property p_user_off;
        s1_v && m_user && !sp_sfr && !sp_op && seg_ptr == 16'h0000
            |=> O_DENY;
    endproperty
    a_user_off: assert property (p_user_off)
        else $error("user access with cleared table pointer");

    property p_coproc;
        s1_v && sp_op && op_rw && s1_req.src == SRC_COPROC |=> O_GRANT;
    endproperty
    a_coproc: assert property (p_coproc)
        else $error("coprocessor operand ram denied");

    property p_cm_rom;
        s1_v && sp_rom && op_r && s1_req.src == SRC_COPY && I_DENY_CM_ROM
            |=> O_DENY;
    endproperty
    a_cm_rom: assert property (p_cm_rom)
        else $error("copy machine rom read not blocked");

    property p_boot_rom;
        s1_v && m_boot && rom_test && op_rx && !cfg_deny |=> O_GRANT;
    endproperty
    a_boot_rom: assert property (p_boot_rom)
        else $error("boot test rom access denied");

endmodule : mac_checker
`default_nettype wire

// file: hw/mac_cm_mode.sv
// copy machine mode holder: mode is frozen at start until done
`timescale 1ns/10ps
`default_nettype none
module mac_cm_mode (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_done,
    input wire mac_pkg::mac_mode_type i_cpu_mode,
    output logic o_busy,
    output mac_pkg::mac_mode_type o_mode
);
    import mac_pkg::*;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_mode <= MODE_BOOT;
        end else if (i_start && !o_busy) begin
            o_busy <= 1'b1;
            o_mode <= i_cpu_mode;
        end else if (i_done) begin
            o_busy <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // mode held busy
    property p_cm_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_busy && !i_done |=> $stable(o_mode);
    endproperty
    a_cm_hold: assert property (p_cm_hold)
        else $error("copy machine mode changed during transfer");

endmodule : mac_cm_mode
`default_nettype wire

// file: hw/mac_pkg.sv
// shared types and constants of the mode based access checker
package mac_pkg;

    // ************************************************************
    // cpu modes, request fields
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_BOOT = 3'h0,
        MODE_TEST = 3'h1,
        MODE_FW = 3'h2,
        MODE_SYS = 3'h3,
        MODE_USER = 3'h4
    } mac_mode_type;

    localparam logic [1:0] SRC_CPU = 2'h0;
    localparam logic [1:0] SRC_COPY = 2'h1;
    localparam logic [1:0] SRC_COPROC = 2'h2;

    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_EXEC = 2'h2;

    localparam logic [2:0] SP_ROM = 3'h0;
    localparam logic [2:0] SP_EE = 3'h1;
    localparam logic [2:0] SP_RAM = 3'h2;
    localparam logic [2:0] SP_SFR = 3'h3;
    localparam logic [2:0] SP_OPRAM = 3'h4;

    // register groups
    localparam logic [3:0] GRP_GEN = 4'h0;
    localparam logic [3:0] GRP_BANK = 4'h1;
    localparam logic [3:0] GRP_SEGCFG = 4'h2;
    localparam logic [3:0] GRP_SYSMGT = 4'h3;
    localparam logic [3:0] GRP_CSR = 4'h4;
    localparam logic [3:0] GRP_SMPTR = 4'h5;
    localparam logic [3:0] GRP_FWCFG = 4'h6;
    localparam logic [3:0] GRP_FWOWN = 4'h7;
    localparam logic [3:0] GRP_TEST = 4'h8;
    localparam logic [3:0] GRP_HW = 4'h9;
    localparam logic [3:0] GRP_CLKSEL = 4'ha;
    localparam logic [3:0] GRP_KEY = 4'hb;

    // ************************************************************
    // memory partition limits (first address above each part; secure eeprom bounds inclusive)
    // ************************************************************
    localparam logic [15:0] ROM_TEST_END = 16'h1000;
    localparam logic [15:0] ROM_FW_END = 16'h4000;
    localparam logic [15:0] EE_FW_END = 16'h2000;
    localparam logic [15:0] EE_SEC_LO = 16'hff00;
    localparam logic [15:0] EE_SEC_HI = 16'hffff;
    localparam logic [15:0] RAM_FW_END = 16'h0800;

    localparam int SEG_COUNT = 64;
    localparam int SEG_IDX_W = 6;
    localparam int HW_GRPS = 16;
    localparam logic [15:0] SEG_PTR_RESET = 16'h0000;

    typedef struct packed {
        logic [1:0] src;
        logic [1:0] op;
        logic [2:0] space;
        logic [3:0] grp;
        logic [3:0] hw_idx;
        logic [15:0] addr;
        logic [5:0] seg;
        logic exec_ee;
    } mac_req_type;

    typedef struct packed {
        logic r;
        logic w;
        logic x;
        logic [15:0] hw;
    } mac_seg_type;

endpackage : mac_pkg

// file: hw/mac_seg_table.sv
// segment table storage, one write port and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module mac_seg_table #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic i_clk,
    input wire logic i_wr,
    input wire logic [AW-1:0] i_wr_idx,
    input wire mac_pkg::mac_seg_type i_wr_data,
    input wire logic [AW-1:0] i_rd_a_idx,
    input wire logic [AW-1:0] i_rd_b_idx,
    output mac_pkg::mac_seg_type o_rd_a,
    output mac_pkg::mac_seg_type o_rd_b
);
    import mac_pkg::*;

    mac_seg_type mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem[i_wr_idx] <= i_wr_data;
        end
        o_rd_a <= mem[i_rd_a_idx];
        o_rd_b <= mem[i_rd_b_idx];
    end

endmodule : mac_seg_table
`default_nettype wire

// file: tb/mac_checker_tb_top.sv
// self-checking bench of the mode based access checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    n_compared++; \
    if ((got) !== (ex)) begin \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
        n_errors++; \
    end
module mac_checker_tb_top;
    import mac_pkg::*;
    logic clk, rst_n, fw_sys, fw_int, fw_ee, d_re, d_cr, d_ce, xe;
    logic ptr_wr, seg_wr, cm_s, cm_d, valid, rv, gr, dn, ex, busy;
    logic [7:0] xb_l, xb_h, xs_l, xs_h;
    logic [15:0] fc_l, fc_h, ptr_d, ptr;
    logic [5:0] seg_i, xseg, sg;
    logic [1:0] src;
    mac_mode_type md;
    mac_seg_type ent;
    mac_req_type rq;
    int n_errors = 0;
    int n_compared = 0;
    mac_checker dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CPU_MODE(md),
        .I_FW_FROM_SYS(fw_sys), .I_FW_INTEGRITY(fw_int),
        .I_FW_EE_ENABLE(fw_ee), .I_DENY_ROM_FROM_EE(d_re),
        .I_DENY_CM_ROM(d_cr), .I_DENY_CM_EE(d_ce),
        .I_EXCHANGE_BASE_LOW(xb_l), .I_EXCHANGE_BASE_HIGH(xb_h),
        .I_EXCHANGE_SIZE_LOW(xs_l), .I_EXCHANGE_SIZE_HIGH(xs_h),
        .I_FIREWALL_CONTROL_LOW(fc_l), .I_FIREWALL_CONTROL_HIGH(fc_h),
        .I_PTR_WR(ptr_wr), .I_PTR_DATA(ptr_d), .I_SEG_WR(seg_wr),
        .I_SEG_IDX(seg_i), .I_SEG_ENTRY(ent), .I_EXEC_SEG(xseg),
        .I_CM_START(cm_s), .I_CM_DONE(cm_d), .I_REQ_VALID(valid),
        .I_REQ(rq), .O_RESP_VALID(rv), .O_GRANT(gr), .O_DENY(dn),
        .O_EXCEPTION(ex), .O_CM_BUSY(busy), .O_SEG_PTR(ptr));
    mac_cpu_model cpu (.i_clk(clk), .o_valid(valid), .o_req(rq),
        .i_resp_valid(rv), .i_grant(gr), .i_deny(dn), .i_exception(ex));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic q(input logic [2:0] sp, input logic [1:0] op,
        input logic [3:0] g, input logic [3:0] h, input logic [15:0] a,
        input logic e);
        logic [3:0] got;
        cpu.access({src, op, sp, g, h, a, sg, xe}, got);
        `CHK("access", {1'b1, e, ~e, ~e & (sp == SP_SFR)}, got)
    endtask : q
    task automatic m(logic [2:0] sp, logic [1:0] op, logic [15:0] a,
        logic e);
        q(sp, op, GRP_GEN, 4'h0, a, e);
    endtask : m
    task automatic r(logic [3:0] g, logic [1:0] op, logic [3:0] h,
        logic e);
        q(SP_SFR, op, g, h, 16'h0000, e);
    endtask : r
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'b1;
        @(posedge clk);
        #1 s = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    task automatic wseg(logic [5:0] i, mac_seg_type v);
        seg_i = i;
        ent = v;
        pulse(seg_wr);
    endtask : wseg
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        `CHK("ptr", 16'h0000, ptr)
        wseg(6'h05, {3'b100, 16'h0004});
        wseg(6'h06, 19'h00000);
        wseg(6'h3f, {3'b111, 16'h0000});
        md = MODE_USER;
        sg = 6'h05;
        m(SP_ROM, OP_READ, 16'h8000, 1'b0);
    endtask : t_reset
    task automatic t_boot();
        md = MODE_BOOT;
        m(SP_ROM, OP_EXEC, 16'h0800, 1'b1);
        m(SP_ROM, OP_READ, 16'h2000, 1'b0);
        m(SP_EE, OP_WRITE, 16'h1000, 1'b1);
        m(SP_EE, OP_READ, 16'h3000, 1'b0);
        m(SP_RAM, OP_WRITE, 16'h0100, 1'b1);
        m(SP_RAM, OP_READ, 16'h1000, 1'b0);
        m(SP_EE, OP_READ, 16'hff10, 1'b1);
        r(GRP_TEST, OP_READ, 4'h0, 1'b0);
        r(GRP_SYSMGT, OP_WRITE, 4'h0, 1'b1);
        r(GRP_SEGCFG, OP_READ, 4'h0, 1'b0);
        r(GRP_BANK, OP_READ, 4'h0, 1'b0);
        r(GRP_GEN, OP_WRITE, 4'h0, 1'b1);
    endtask : t_boot
    task automatic t_test();
        md = MODE_TEST;
        m(SP_ROM, OP_EXEC, 16'h8000, 1'b1);
        m(SP_ROM, OP_WRITE, 16'h0100, 1'b0);
        m(SP_EE, OP_EXEC, 16'h3000, 1'b1);
        m(SP_RAM, OP_WRITE, 16'h1000, 1'b1);
        r(GRP_TEST, OP_WRITE, 4'h0, 1'b1);
        r(GRP_BANK, OP_WRITE, 4'h0, 1'b0);
    endtask : t_test
    task automatic t_fw();
        md = MODE_FW;
        fw_ee = 1'b1;
        m(SP_ROM, OP_READ, 16'h2000, 1'b1);
        m(SP_ROM, OP_READ, 16'h8000, 1'b0);
        m(SP_RAM, OP_WRITE, 16'h0100, 1'b1);
        m(SP_EE, OP_EXEC, 16'h1000, 1'b1);
        m(SP_RAM, OP_WRITE, 16'h1080, 1'b1);
        m(SP_RAM, OP_WRITE, 16'h1100, 1'b0);
        m(SP_EE, OP_READ, 16'hff10, 1'b1);
        m(SP_EE, OP_WRITE, 16'h3000, 1'b0);
        fw_sys = 1'b1;
        m(SP_EE, OP_WRITE, 16'h3000, 1'b1);
        {fw_sys, fw_int, fw_ee} = 3'b010;
        m(SP_EE, OP_WRITE, 16'h3000, 1'b1);
        fw_int = 1'b0;
        m(SP_EE, OP_EXEC, 16'h1000, 1'b0);
        r(GRP_HW, OP_READ, 4'h3, 1'b1);
        r(GRP_HW, OP_WRITE, 4'h3, 1'b0);
        r(GRP_HW, OP_READ, 4'h2, 1'b0);
        r(GRP_FWCFG, OP_READ, 4'h0, 1'b1);
        r(GRP_FWOWN, OP_WRITE, 4'h0, 1'b1);
        r(GRP_CSR, OP_READ, 4'h0, 1'b1);
        r(GRP_CLKSEL, OP_READ, 4'h2, 1'b1);
        r(GRP_BANK, OP_READ, 4'h0, 1'b0);
    endtask : t_fw
    task automatic t_copy();
        md = MODE_SYS;
        sg = 6'h06;
        pulse(cm_s);
        md = MODE_USER;
        src = SRC_COPY;
        m(SP_ROM, OP_READ, 16'h8000, 1'b1);
        `CHK("busy", 1'b1, busy)
        {d_cr, d_ce} = 2'b11;
        m(SP_ROM, OP_READ, 16'h8000, 1'b0);
        m(SP_EE, OP_READ, 16'h3000, 1'b0);
        pulse(cm_d);
        {d_cr, d_ce, src} = {2'b00, SRC_CPU};
        `CHK("busy", 1'b0, busy)
    endtask : t_copy
    task automatic t_sys();
        md = MODE_SYS;
        m(SP_ROM, OP_READ, 16'h8000, 1'b1);
        m(SP_ROM, OP_READ, 16'h2000, 1'b0);
        m(SP_EE, OP_EXEC, 16'h3000, 1'b1);
        m(SP_RAM, OP_READ, 16'h0100, 1'b0);
        {xe, d_re} = 2'b11;
        m(SP_ROM, OP_READ, 16'h8000, 1'b0);
        {xe, d_re} = 2'b00;
        r(GRP_SEGCFG, OP_WRITE, 4'h0, 1'b1);
        r(GRP_HW, OP_WRITE, 4'h2, 1'b1);
        r(GRP_SMPTR, OP_READ, 4'h0, 1'b0);
        r(GRP_KEY, OP_READ, 4'h0, 1'b0);
        r(GRP_BANK, OP_WRITE, 4'h0, 1'b1);
        ptr_d = 16'h0040;
        pulse(ptr_wr);
        `CHK("ptr", 16'h0040, ptr)
    endtask : t_sys
    task automatic t_user();
        md = MODE_USER;
        ptr_d = 16'h0000;
        pulse(ptr_wr);
        `CHK("ptr", 16'h0040, ptr)
        sg = 6'h05;
        m(SP_ROM, OP_READ, 16'h8000, 1'b1);
        m(SP_ROM, OP_EXEC, 16'h8000, 1'b0);
        m(SP_EE, OP_WRITE, 16'h3000, 1'b0);
        sg = 6'h06;
        m(SP_EE, OP_READ, 16'h3000, 1'b0);
        sg = 6'h3f;
        m(SP_RAM, OP_WRITE, 16'h1000, 1'b1);
        m(SP_RAM, OP_WRITE, 16'h0100, 1'b0);
        r(GRP_HW, OP_READ, 4'h2, 1'b1);
        r(GRP_HW, OP_READ, 4'h3, 1'b0);
        r(GRP_SEGCFG, OP_READ, 4'h0, 1'b0);
        r(GRP_CSR, OP_READ, 4'h0, 1'b1);
        m(SP_OPRAM, OP_WRITE, 16'h0000, 1'b0);
        src = SRC_COPROC;
        m(SP_OPRAM, OP_WRITE, 16'h0000, 1'b1);
        // mid-run reset must clear a written table pointer again
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("ptr", 16'h0000, ptr)
        src = SRC_CPU;
        m(SP_RAM, OP_WRITE, 16'h1000, 1'b0);
    endtask : t_user
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
    initial begin
        {fw_sys, fw_int, fw_ee, d_re, d_cr, d_ce, xe} = '0;
        {ptr_wr, seg_wr, cm_s, cm_d, rst_n} = '0;
        {xb_h, xb_l, xs_h, xs_l} = 32'h1000_0100;
        {fc_h, fc_l, ptr_d} = {16'h0000, 16'h0008, 16'h0000};
        {seg_i, xseg, sg, src} = {6'h00, 6'h05, 6'h00, SRC_CPU};
        md = MODE_BOOT;
        ent = '0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_boot();
        t_test();
        t_fw();
        t_copy();
        t_sys();
        t_user();
        conclude();
    end
endmodule : mac_checker_tb_top
`default_nettype wire

// file: tb/mac_cpu_model.sv
// cpu side request issuer for the access checker
`timescale 1ns/10ps
`default_nettype none
module mac_cpu_model (
    input wire logic i_clk,
    output logic o_valid,
    output mac_pkg::mac_req_type o_req,
    input wire logic i_resp_valid,
    input wire logic i_grant,
    input wire logic i_deny,
    input wire logic i_exception
);
    import mac_pkg::*;
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end
    // one request; the answer is read one edge after it is taken
    task automatic access(input mac_req_type r, output logic [3:0] resp);
        @(posedge i_clk);
        #1 o_valid = 1'b1;
        o_req = r;
        @(posedge i_clk);
        #1 o_valid = 1'b0;
        // released request lines no longer show the old value
        o_req = ~r;
        @(posedge i_clk);
        #1 resp = {i_resp_valid, i_grant, i_deny, i_exception};
    endtask : access
endmodule : mac_cpu_model
`default_nettype wire
